// ### shared/tcm_defines.svh
// Register indices, field positions, reset values and widths of the control and monitor bank
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

`define TCM_IDX_W          7
`define TCM_IDX_CCR3       7'h72
`define TCM_IDX_CCR4       7'h73
`define TCM_IDX_TXSEL      7'h74
`define TCM_IDX_TXMON      7'h75
`define TCM_IDX_RXSEL      7'h76
`define TCM_IDX_RXMON      7'h77
`define TCM_IDX_LIC1       7'h78
`define TCM_IDX_LMODE      7'h79
`define TCM_IDX_LBCTL      7'h7A

`define TCM_RST_BYTE       8'h00

`define TCM_CCR3_MFSRC     7
`define TCM_CCR3_IRQOFF    6
`define TCM_CCR3_TXFMT     3
`define TCM_CCR3_TXGAP     2
`define TCM_CCR3_RXFMT     1
`define TCM_CCR3_RXGAP     0
`define TCM_CCR3_MASK      8'hCF

`define TCM_CCR4_MASK      8'hF0
`define TCM_LVL_LSB        4
`define TCM_SEL_MASK       8'h1F

`define TCM_LIC1_BO_LSB    5
`define TCM_LIC1_EGL       4
`define TCM_LIC1_JAS       3
`define TCM_LIC1_JITTER_ATTEN_DEPTH     2
`define TCM_LIC1_DJA       1
`define TCM_LIC1_TPD       0

`define TCM_LMODE_BIT      7
`define TCM_LBCTL_BIT      7
`define TCM_TOP_MASK       8'h80

`define TCM_BO_LEGACY_A    3'h4
`define TCM_BO_LEGACY_B    3'h5

`endif

// ### shared/tcm_pkg.sv
// Types shared by the control and monitor bank
package tcm_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [8:0]  adr;
    logic [31:0] dat;
  } tcm_wb_req_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] data;
  } tcm_chan_byte_t;

  typedef enum logic [1:0] {
    SENS_T1_36DB = 2'h0,
    SENS_T1_15DB = 2'h1,
    SENS_E1_12DB = 2'h3,
    SENS_E1_43DB = 2'h2
  } tcm_sens_t;

endpackage : tcm_pkg

// ### design/tcm_ctrl_monitor.sv
// Common control, line interface and channel monitor register bank of one transceiver
`include "tcm_defines.svh"

module tcm_ctrl_monitor (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire tcm_pkg::tcm_wb_req_t wbReq,
  output logic [31:0]               wbDatOut,
  output logic                      wbAck,
  input  wire tcm_pkg::tcm_chan_byte_t txChanByte,
  input  wire tcm_pkg::tcm_chan_byte_t rxChanByte,
  input  wire logic                 irqRaw,
  input  wire logic                 txPowerDownPin,
  input  wire logic                 txLineDataA,
  input  wire logic                 txLineDataB,
  output logic                      irqOut,
  output logic                      txMfSyncFromFramer,
  output logic                      txChannelFormat56k,
  output logic                      rxChannelFormat56k,
  output logic                      txGappedClockEn,
  output logic                      rxGappedClockEn,
  output logic [3:0]                rxLevelThreshold,
  output logic [2:0]                buildOutSelect,
  output logic                      buildOutLegacy,
  output tcm_pkg::tcm_sens_t        eqSensitivity,
  output logic                      lineModeE1,
  output logic                      jitterAttenOnTx,
  output logic                      jitterAttenDepth32,
  output logic                      jitterAttenBypass,
  output logic                      txEnable,
  output logic                      txLineOutA,
  output logic                      txLineOutAOe_n,
  output logic                      txLineOutB,
  output logic                      txLineOutBOe_n
);
  import tcm_pkg::*;

  logic [7:0] ccr3_q;
  logic [7:0] ccr4_q;
  logic [7:0] txSel_q;
  logic [7:0] rxSel_q;
  logic [7:0] txMon_q;
  logic [7:0] rxMon_q;
  logic [7:0] lic1_q;
  logic [7:0] lmode_q;
  logic [7:0] lbctl_q;
  logic       pdMeta_q;
  logic       pdSync_q;
  logic       ack_q;
  logic [31:0] rdData_q;
  logic       txRun;
  logic       wrStrobe;
  logic [`TCM_IDX_W-1:0] idx;

  // True when a channel byte belongs to the channel that software selected
  function automatic logic chanHit(input tcm_chan_byte_t cb, input logic [7:0] sel);
    chanHit = cb.valid && (cb.chan == sel[4:0]);
  endfunction : chanHit

  // Register view as software reads it; reserved bits and unmapped indices read zero
  function automatic logic [7:0] readReg(input logic [`TCM_IDX_W-1:0] i);
    case (i)
      `TCM_IDX_CCR3:  readReg = ccr3_q;
      `TCM_IDX_CCR4:  readReg = ccr4_q;
      `TCM_IDX_TXSEL: readReg = txSel_q;
      `TCM_IDX_TXMON: readReg = txMon_q;
      `TCM_IDX_RXSEL: readReg = rxSel_q;
      `TCM_IDX_RXMON: readReg = rxMon_q;
      `TCM_IDX_LIC1:  readReg = lic1_q;
      `TCM_IDX_LMODE: readReg = lmode_q;
      `TCM_IDX_LBCTL: readReg = lbctl_q;
      default:        readReg = `TCM_RST_BYTE;
    endcase
  endfunction : readReg

  assign idx      = wbReq.adr[8:2];
  // Writes land on the acknowledged edge, so a cycle dropped before ack stores nothing
  assign wrStrobe = wbReq.cyc && wbReq.stb && wbReq.we && ack_q && wbReq.sel[0];

  // Bus slave: one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wbReq.cyc && wbReq.stb && !ack_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (wbReq.cyc && wbReq.stb && !wbReq.we && !ack_q) begin
      rdData_q <= {24'h00_0000, readReg(idx)};
    end else begin
      rdData_q <= 32'h0000_0000;
    end
  end

  assign wbAck    = ack_q;
  assign wbDatOut = rdData_q;

  // Common control: sync source, interrupt disable, formats and gapped clocks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ccr3_q <= `TCM_RST_BYTE;
    end else if (wrStrobe && idx == `TCM_IDX_CCR3) begin
      ccr3_q <= wbReq.dat[7:0] & `TCM_CCR3_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ccr4_q <= `TCM_RST_BYTE;
    end else if (wrStrobe && idx == `TCM_IDX_CCR4) begin
      ccr4_q <= wbReq.dat[7:0] & `TCM_CCR4_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txSel_q <= `TCM_RST_BYTE;
      rxSel_q <= `TCM_RST_BYTE;
    end else if (wrStrobe && idx == `TCM_IDX_TXSEL) begin
      txSel_q <= wbReq.dat[7:0] & `TCM_SEL_MASK;
    end else if (wrStrobe && idx == `TCM_IDX_RXSEL) begin
      rxSel_q <= wbReq.dat[7:0] & `TCM_SEL_MASK;
    end
  end

  // Line interface control; any build-out code is stored, the legacy ones included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lic1_q <= `TCM_RST_BYTE;
    end else if (wrStrobe && idx == `TCM_IDX_LIC1) begin
      lic1_q <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lmode_q <= `TCM_RST_BYTE;
      lbctl_q <= `TCM_RST_BYTE;
    end else if (wrStrobe && idx == `TCM_IDX_LMODE) begin
      lmode_q <= wbReq.dat[7:0] & `TCM_TOP_MASK;
    end else if (wrStrobe && idx == `TCM_IDX_LBCTL) begin
      lbctl_q <= wbReq.dat[7:0] & `TCM_TOP_MASK;
    end
  end

  // Monitors take the selected channel as it passes, which is once per frame.
  // Bus writes never reach them, so software cannot corrupt a captured byte.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txMon_q <= `TCM_RST_BYTE;
    end else if (chanHit(txChanByte, txSel_q)) begin
      txMon_q <= txChanByte.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxMon_q <= `TCM_RST_BYTE;
    end else if (chanHit(rxChanByte, rxSel_q)) begin
      rxMon_q <= rxChanByte.data;
    end
  end

  // Power-down pin comes from outside, so it is synchronised first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdMeta_q <= 1'b0;
      pdSync_q <= 1'b0;
    end else begin
      pdMeta_q <= txPowerDownPin;
      pdSync_q <= pdMeta_q;
    end
  end

  assign txRun = lic1_q[`TCM_LIC1_TPD] && (!lbctl_q[`TCM_LBCTL_BIT] || !pdSync_q);

  // Transmit line drivers float while powered down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txEnable       <= 1'b0;
      txLineOutA     <= 1'b0;
      txLineOutB     <= 1'b0;
      txLineOutAOe_n <= 1'b1;
      txLineOutBOe_n <= 1'b1;
    end else begin
      txEnable       <= txRun;
      txLineOutA     <= txRun && txLineDataA;
      txLineOutB     <= txRun && txLineDataB;
      txLineOutAOe_n <= !txRun;
      txLineOutBOe_n <= !txRun;
    end
  end

  // Interrupt gate; the mask registers live upstream and feed irqRaw
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= irqRaw && !ccr3_q[`TCM_CCR3_IRQOFF];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txMfSyncFromFramer <= 1'b0;
      txChannelFormat56k <= 1'b0;
      rxChannelFormat56k <= 1'b0;
      txGappedClockEn    <= 1'b0;
      rxGappedClockEn    <= 1'b0;
      rxLevelThreshold   <= 4'h0;
    end else begin
      txMfSyncFromFramer <= ccr3_q[`TCM_CCR3_MFSRC];
      txChannelFormat56k <= ccr3_q[`TCM_CCR3_TXFMT];
      rxChannelFormat56k <= ccr3_q[`TCM_CCR3_RXFMT];
      txGappedClockEn    <= ccr3_q[`TCM_CCR3_TXGAP];
      rxGappedClockEn    <= ccr3_q[`TCM_CCR3_RXGAP];
      rxLevelThreshold   <= ccr4_q[`TCM_LVL_LSB +: 4];
    end
  end

  // Gain limit meaning flips with the line mode, so both feed one code
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eqSensitivity <= SENS_T1_36DB;
      lineModeE1    <= 1'b0;
    end else begin
      lineModeE1 <= lmode_q[`TCM_LMODE_BIT];
      case ({lmode_q[`TCM_LMODE_BIT], lic1_q[`TCM_LIC1_EGL]})
        2'b00:   eqSensitivity <= SENS_T1_36DB;
        2'b01:   eqSensitivity <= SENS_T1_15DB;
        2'b10:   eqSensitivity <= SENS_E1_12DB;
        2'b11:   eqSensitivity <= SENS_E1_43DB;
        default: eqSensitivity <= SENS_T1_36DB;
      endcase
    end
  end

  // Build-out select is passed through; the termination choice is software's
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buildOutSelect     <= 3'h0;
      buildOutLegacy     <= 1'b0;
      jitterAttenOnTx    <= 1'b0;
      jitterAttenDepth32 <= 1'b0;
      jitterAttenBypass  <= 1'b0;
    end else begin
      buildOutSelect     <= lic1_q[`TCM_LIC1_BO_LSB +: 3];
      buildOutLegacy     <= (lic1_q[`TCM_LIC1_BO_LSB +: 3] == `TCM_BO_LEGACY_A) ||
                            (lic1_q[`TCM_LIC1_BO_LSB +: 3] == `TCM_BO_LEGACY_B);
      jitterAttenOnTx    <= lic1_q[`TCM_LIC1_JAS];
      jitterAttenDepth32 <= lic1_q[`TCM_LIC1_JITTER_ATTEN_DEPTH];
      jitterAttenBypass  <= lic1_q[`TCM_LIC1_DJA];
    end
  end

  a_irq_gate_off:
  assert property (@(posedge clk_sys) disable iff (rst)
    ccr3_q[`TCM_CCR3_IRQOFF] |=> !irqOut)
    else $error("interrupt passed while globally disabled");

  a_irq_follows_raw:
  assert property (@(posedge clk_sys) disable iff (rst)
    (irqRaw && !ccr3_q[`TCM_CCR3_IRQOFF]) |=> irqOut)
    else $error("enabled interrupt not forwarded");

  a_tx_power_table:
  assert property (@(posedge clk_sys) disable iff (rst)
    ##1 txEnable == $past(lic1_q[0] && (!lbctl_q[7] || !pdSync_q)))
    else $error("transmit enable disagrees with power-down table");

  a_tx_lines_float:
  assert property (@(posedge clk_sys) disable iff (rst)
    !txEnable |-> (txLineOutAOe_n && txLineOutBOe_n && !txLineOutA && !txLineOutB))
    else $error("line driven while powered down");

  a_tx_mon_capture:
  assert property (@(posedge clk_sys) disable iff (rst)
    (txChanByte.valid && txChanByte.chan == txSel_q[4:0]) |=>
      txMon_q == $past(txChanByte.data))
    else $error("transmit monitor missed selected channel");

  a_rx_mon_capture:
  assert property (@(posedge clk_sys) disable iff (rst)
    (rxChanByte.valid && rxChanByte.chan == rxSel_q[4:0]) |=>
      rxMon_q == $past(rxChanByte.data))
    else $error("receive monitor missed selected channel");

  a_mon_write_ignored:
  assert property (@(posedge clk_sys) disable iff (rst)
    (wrStrobe && idx == `TCM_IDX_TXMON && !txChanByte.valid) |=> $stable(txMon_q))
    else $error("monitor changed by a bus write");

  a_sens_mode_map:
  assert property (@(posedge clk_sys) disable iff (rst)
    (lmode_q[7] && !lic1_q[4]) |=> eqSensitivity == SENS_E1_12DB)
    else $error("E1 gain limit zero not mapped to short haul");

  a_ja_path_bits:
  assert property (@(posedge clk_sys) disable iff (rst)
    ##1 {jitterAttenOnTx, jitterAttenDepth32, jitterAttenBypass} == $past(lic1_q[3:1]))
    else $error("jitter attenuator outputs do not follow control");

  a_ack_single:
  assert property (@(posedge clk_sys) disable iff (rst)
    wbAck |=> !wbAck)
    else $error("bus acknowledge held longer than one cycle");

  a_level_follows:
  assert property (@(posedge clk_sys) disable iff (rst)
    ##1 rxLevelThreshold == $past(ccr4_q[7:4]))
    else $error("receive level threshold does not follow control");

  a_bo_legacy_flag:
  assert property (@(posedge clk_sys) disable iff (rst)
    ##1 buildOutLegacy == $past(lic1_q[7:6] == 2'b10))
    else $error("legacy build-out code not flagged");

  a_fmt_gap_bits:
  assert property (@(posedge clk_sys) disable iff (rst)
    ##1 {txChannelFormat56k, rxChannelFormat56k, txGappedClockEn, rxGappedClockEn} ==
        $past({ccr3_q[3], ccr3_q[1], ccr3_q[2], ccr3_q[0]}))
    else $error("channel format or gapped clock outputs do not follow control");

endmodule : tcm_ctrl_monitor

// ### tb/test_tcm_ctrl_monitor.sv
// Self-checking testbench of the control and monitor register bank
`include "tcm_defines.svh"
module test_tcm_ctrl_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;

  logic           clk_sys, rst, wbAck, irqRaw, txPowerDownPin, txLineDataA, txLineDataB;
  tcm_wb_req_t    wbReq;
  tcm_chan_byte_t txChanByte, rxChanByte;
  logic [31:0]    wbDatOut, rngState, r, rd;
  logic           irqOut, txMfSyncFromFramer, txChannelFormat56k, rxChannelFormat56k;
  logic           txGappedClockEn, rxGappedClockEn, buildOutLegacy, lineModeE1, en;
  logic           jitterAttenOnTx, jitterAttenDepth32, jitterAttenBypass, txEnable;
  logic           txLineOutA, txLineOutAOe_n, txLineOutB, txLineOutBOe_n;
  logic [3:0]     rxLevelThreshold;
  logic [2:0]     buildOutSelect;
  tcm_sens_t      eqSensitivity;
  logic [7:0]     d;
  logic [4:0]     tch, rch;
  int             mismatches, nTests;

  tcm_ctrl_monitor u_dut (
    .clk_sys, .rst, .wbReq, .wbDatOut, .wbAck, .txChanByte, .rxChanByte, .irqRaw,
    .txPowerDownPin, .txLineDataA, .txLineDataB, .irqOut, .txMfSyncFromFramer,
    .txChannelFormat56k, .rxChannelFormat56k, .txGappedClockEn, .rxGappedClockEn,
    .rxLevelThreshold, .buildOutSelect, .buildOutLegacy, .eqSensitivity, .lineModeE1,
    .jitterAttenOnTx, .jitterAttenDepth32, .jitterAttenBypass, .txEnable, .txLineOutA,
    .txLineOutAOe_n, .txLineOutB, .txLineOutBOe_n
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function logic [31:0] nextRand();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : nextRand

  function tcm_sens_t expSens(input logic e1, input logic equalizer_gain_limit);
    return e1 ? (equalizer_gain_limit ? SENS_E1_43DB : SENS_E1_12DB) : (equalizer_gain_limit ? SENS_T1_15DB : SENS_T1_36DB);
  endfunction : expSens

  // Pin only matters while the loopback select is set
  function logic expEn(input logic loopback_ctl_select, input logic pin, input logic tx_power_down_ctl);
    return tx_power_down_ctl & (~loopback_ctl_select | ~pin);
  endfunction : expEn

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop();
    $display("Checks %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Called just after a rising edge; no fixed answer time is assumed
  task wbXfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
              output logic [31:0] rdat);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: wr, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h0, wd}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rdat = wbDatOut;
    if (n >= 20) check(32'h0, 32'h1);
    wbReq <= '0;
    @(posedge clk_sys);
  endtask : wbXfer

  task wrReg(input logic [6:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    wbXfer(1'b1, idx, wd, x);
  endtask : wrReg

  task rdChk(input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    wbXfer(1'b0, idx, 8'h00, x);
    check(x, {24'h0, exp});
  endtask : rdChk

  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end

  initial begin
    rngState = 32'h00017F75;
    mismatches = 0;
    nTests = 0;
    rst = 1'b1;
    wbReq = '0;
    txChanByte = '0;
    rxChanByte = '0;
    irqRaw = 1'b0;
    txPowerDownPin = 1'b0;
    txLineDataA = 1'b0;
    txLineDataB = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check({28'h0, txEnable, txLineOutAOe_n, txLineOutBOe_n, txLineOutA}, 32'h6);
    for (int i = 8'h72; i <= 8'h7A; i++) rdChk(7'(i), 8'h00);
    for (int i = 0; i < 12; i++) begin
      r = nextRand();
      d = (i < 2) ? {8{i[0]}} : r[7:0];
      irqRaw <= r[8] | (i < 2);
      wrReg(`TCM_IDX_CCR3, d);
      rdChk(`TCM_IDX_CCR3, d & `TCM_CCR3_MASK);
      check({26'h0, txMfSyncFromFramer, irqOut, txChannelFormat56k, txGappedClockEn,
             rxChannelFormat56k, rxGappedClockEn},
            {26'h0, d[7], irqRaw & ~d[6], d[3], d[2], d[1], d[0]});
      d = (i < 2) ? {8{i[0]}} : r[15:8];
      wrReg(`TCM_IDX_CCR4, d);
      rdChk(`TCM_IDX_CCR4, d & `TCM_CCR4_MASK);
      check({28'h0, rxLevelThreshold}, {28'h0, d[7:4]});
      wrReg(`TCM_IDX_TXSEL, r[23:16]);
      rdChk(`TCM_IDX_TXSEL, r[23:16] & `TCM_SEL_MASK);
      wrReg(`TCM_IDX_RXSEL, r[31:24]);
      rdChk(`TCM_IDX_RXSEL, r[31:24] & `TCM_SEL_MASK);
    end
    for (int i = 0; i < 16; i++) begin
      r = nextRand();
      d = {i[2:0], r[4:0]};
      wrReg(`TCM_IDX_LMODE, {i[3], r[14:8]});
      rdChk(`TCM_IDX_LMODE, {i[3], 7'h0});
      wrReg(`TCM_IDX_LIC1, d);
      rdChk(`TCM_IDX_LIC1, d);
      check({22'h0, buildOutSelect, buildOutLegacy, eqSensitivity, lineModeE1,
             jitterAttenOnTx, jitterAttenDepth32, jitterAttenBypass},
            {22'h0, d[7:5], d[7:5] == 3'h4 || d[7:5] == 3'h5, expSens(i[3], d[4]), i[3],
             d[3], d[2], d[1]});
    end
    for (int i = 0; i < 8; i++) begin
      r = nextRand();
      wrReg(`TCM_IDX_LBCTL, {i[2], 7'h0});
      wrReg(`TCM_IDX_LIC1, {r[7:1], i[0]});
      txPowerDownPin <= i[1];
      txLineDataA <= r[8];
      txLineDataB <= r[9];
      repeat (4) @(posedge clk_sys);
      en = expEn(i[2], i[1], i[0]);
      check({27'h0, txEnable, txLineOutAOe_n, txLineOutBOe_n, txLineOutA, txLineOutB},
            {27'h0, en, ~en, ~en, en & r[8], en & r[9]});
    end
    for (int i = 0; i < 8; i++) begin
      r = nextRand();
      tch = (i == 0) ? 5'h1F : r[4:0];
      rch = (i == 0) ? 5'h00 : r[12:8];
      wrReg(`TCM_IDX_TXSEL, {3'h7, tch});
      wrReg(`TCM_IDX_RXSEL, {3'h7, rch});
      // Wrong channel first, then the selected one back to back
      txChanByte <= '{valid: 1'b1, chan: tch ^ 5'h01, data: ~r[23:16]};
      rxChanByte <= '{valid: 1'b1, chan: rch ^ 5'h10, data: ~r[31:24]};
      @(posedge clk_sys);
      txChanByte <= '{valid: 1'b1, chan: tch, data: r[23:16]};
      rxChanByte <= '{valid: 1'b1, chan: rch, data: r[31:24]};
      @(posedge clk_sys);
      txChanByte <= '{valid: 1'b1, chan: tch + 5'h1, data: 8'hA5};
      rxChanByte <= '{valid: 1'b1, chan: rch - 5'h1, data: 8'h5A};
      @(posedge clk_sys);
      txChanByte <= '0;
      rxChanByte <= '0;
      @(posedge clk_sys);
      wrReg(`TCM_IDX_TXMON, ~r[23:16]);
      wrReg(`TCM_IDX_RXMON, ~r[31:24]);
      rdChk(`TCM_IDX_TXMON, r[23:16]);
      rdChk(`TCM_IDX_RXMON, r[31:24]);
    end
    // Unmapped place still answers, holds nothing
    wrReg(7'h10, 8'hFF);
    rdChk(7'h10, 8'h00);
    wbXfer(1'b0, `TCM_IDX_LBCTL, 8'h00, rd);
    check(rd, 32'h00000080);
    // Second reset in mid-run clears stored bytes and powers the transmitter down
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdChk(`TCM_IDX_TXMON, 8'h00);
    rdChk(`TCM_IDX_LIC1, 8'h00);
    check({31'h0, txEnable}, 32'h0);
    report_and_stop();
  end
endmodule : test_tcm_ctrl_monitor
